// [verilog/nvm_erase_write_ctrl.sv]
// Data EEPROM erase/write controller with page buffer, cycle timer and array storage
// ============================================================================
// Summary of operation
// - Page mode erase clears only tagged bytes of one sixteen-byte page.
// - Reset empties the page buffer and its tags.
// - Erase enable falling clears the page buffer; rising leaves it.
// - Write enable falling clears the page buffer; rising leaves it.
// - Upper seven address bits pick page, never incremented; low four pick byte.
// - Page mode data write tags current address, then low nibble advances.
// - Low nibble stops at 0f, never wraps to page start.
// - After stopping at the page end, further data writes update only the data register, not the buffer.
// - Page mode data write stores byte in buffer at current address, advances.
// - Write trigger with write enable clear starts nothing.
// - Cycles are timed by an internal timer; trigger bit shows completion.
// - Erase end clears erase trigger, then erase enable.
// - Erased locations read back as zero.
// - Write end clears write trigger, then write enable.
// - Byte mode write programs data register at the held address.
// - Byte write erases the addressed byte first, then programs it.
// - Write enable is clear after reset.
// - Time select picks 3.2/2.2 ms or 3.7/3.0 ms erase/write times.
// - Erase trigger with erase enable clear has no effect.
// - Every cycle end sets a done flag that holds until software clears it.
//
// Our own choices: strobed register access and the register addresses.
`timescale 1ns/10ps
module nvm_erase_write_ctrl #(
  parameter int unsigned ERASE_T0_CYC = nvm_ctrl_pkg::ERASE_T0_CYC,
  parameter int unsigned WRITE_T0_CYC = nvm_ctrl_pkg::WRITE_T0_CYC,
  parameter int unsigned ERASE_T1_CYC = nvm_ctrl_pkg::ERASE_T1_CYC,
  parameter int unsigned WRITE_T1_CYC = nvm_ctrl_pkg::WRITE_T1_CYC
) (
  input  wire logic       CLK_SYS,
  input  wire logic       RST_N,
  input  wire logic [2:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  input  wire logic       REG_WR,
  input  wire logic       REG_RD,
  output logic      [7:0] REG_RDATA,
  output logic            NVM_DONE_FLAG,
  output logic            BUSY
);

  localparam int DEPTH = 1 << nvm_ctrl_pkg::ADDR_W;
  localparam int NB    = nvm_ctrl_pkg::PAGE_BYTES;

  // ==========================================================================
  // State
  nvm_ctrl_pkg::ctrl_s  ctrl_q;
  nvm_ctrl_pkg::ctrl_s  ctrl_d;
  nvm_ctrl_pkg::state_e state_q;
  nvm_ctrl_pkg::state_e state_d;
  logic [7:0]           addr_low_q;
  logic [7:0]           addr_low_d;
  logic [2:0]           addr_high_q;
  logic [2:0]           addr_high_d;
  logic [7:0]           data_q;
  logic [7:0]           data_d;
  logic [7:0]           buf_q [NB];
  logic [7:0]           buf_d [NB];
  logic [NB-1:0]        tag_q;
  logic [NB-1:0]        tag_d;
  logic                 sat_q;
  logic                 sat_d;
  logic                 erase_arm_q;
  logic                 erase_arm_d;
  logic                 write_arm_q;
  logic                 write_arm_d;
  logic                 prev_ee_q;
  logic                 prev_ee_d;
  logic                 prev_we_q;
  logic                 prev_we_d;
  logic [31:0]          cnt_q;
  logic [31:0]          cnt_d;
  logic                 end_q;
  logic                 end_d;
  logic                 clr_ee_q;
  logic                 clr_ee_d;
  logic                 clr_we_q;
  logic                 clr_we_d;
  logic                 done_q;
  logic                 done_d;
  logic [7:0]           rdata_q;
  logic [7:0]           rdata_d;
  logic [7:0]           mem_q [DEPTH];
  logic [7:0]           mem_d [DEPTH];

  // ==========================================================================
  // Decoded strobes and array operations
  nvm_ctrl_pkg::ctrl_s  wctl;
  logic [10:0]          full_addr;
  logic [3:0]           ofs;
  logic                 idle;
  logic                 wr_ctrl;
  logic                 wr_data;
  logic                 erase_go;
  logic                 byte_erase_go;
  logic                 program_go;
  logic [31:0]          erase_cyc;
  logic [31:0]          write_cyc;

  assign wctl      = nvm_ctrl_pkg::ctrl_s'(REG_WDATA);
  assign full_addr = {addr_high_q, addr_low_q};
  assign ofs       = addr_low_q[3:0];
  assign idle      = (state_q == nvm_ctrl_pkg::ST_IDLE);
  assign wr_ctrl   = REG_WR && (REG_ADDR == nvm_ctrl_pkg::REG_CTRL);
  assign wr_data   = REG_WR && (REG_ADDR == nvm_ctrl_pkg::REG_DATA);
  // Timer end is acted on only once registered in end_q
  assign erase_go      = end_q && (state_q == nvm_ctrl_pkg::ST_ERASE);
  assign byte_erase_go = end_q && (state_q == nvm_ctrl_pkg::ST_BYTE_ERASE);
  assign program_go    = end_q && (state_q == nvm_ctrl_pkg::ST_PROGRAM);
  assign erase_cyc = ctrl_q.cycle_time_select ? ERASE_T1_CYC : ERASE_T0_CYC;
  assign write_cyc = ctrl_q.cycle_time_select ? WRITE_T1_CYC : WRITE_T0_CYC;

  assign REG_RDATA     = rdata_q;
  assign NVM_DONE_FLAG = done_q;
  assign BUSY          = !idle;

  // ==========================================================================
  // Control, address, buffer and timer
  always_comb begin
    ctrl_d      = ctrl_q;
    state_d     = state_q;
    addr_low_d  = addr_low_q;
    addr_high_d = addr_high_q;
    data_d      = data_q;
    buf_d       = buf_q;
    tag_d       = tag_q;
    sat_d       = sat_q;
    erase_arm_d = erase_arm_q;
    write_arm_d = write_arm_q;
    prev_ee_d   = ctrl_q.erase_enable;
    prev_we_d   = ctrl_q.write_enable_bit;
    cnt_d       = cnt_q;
    end_d       = 1'b0;
    clr_ee_d    = 1'b0;
    clr_we_d    = 1'b0;
    done_d      = done_q;
    rdata_d     = 8'h00;

    // Activation window lasts only until the next bus access
    if (REG_WR || REG_RD) begin
      erase_arm_d = 1'b0;
      write_arm_d = 1'b0;
    end

    // Register writes other than the done clear are ignored while a cycle runs, so mid-cycle edits cannot
    // disturb the address or buffer being committed
    if (REG_WR && idle) begin
      if (REG_ADDR == nvm_ctrl_pkg::REG_ADDR_LOW) begin
        addr_low_d = REG_WDATA;
        sat_d      = 1'b0;
      end else if (REG_ADDR == nvm_ctrl_pkg::REG_ADDR_HIGH) begin
        addr_high_d = REG_WDATA[2:0];
      end else if (wr_data) begin
        data_d = REG_WDATA;
        if (ctrl_q.page_mode && !sat_q) begin
          buf_d[ofs] = REG_WDATA;
          tag_d[ofs] = 1'b1;
          if (ofs == nvm_ctrl_pkg::OFS_LAST) begin
            sat_d = 1'b1;
          end else begin
            addr_low_d[3:0] = ofs + 4'h1;
          end
        end
      end else if (wr_ctrl) begin
        ctrl_d.cycle_time_select = wctl.cycle_time_select;
        ctrl_d.page_mode         = wctl.page_mode;
        ctrl_d.erase_enable      = wctl.erase_enable;
        ctrl_d.write_enable_bit  = wctl.write_enable_bit;
        ctrl_d.erase_trigger     = 1'b0;
        ctrl_d.write_trigger     = 1'b0;
        // Enable and trigger in one write never activate
        erase_arm_d = wctl.erase_enable && !ctrl_q.erase_enable && !wctl.erase_trigger;
        write_arm_d = wctl.write_enable_bit && !ctrl_q.write_enable_bit
                      && !wctl.write_trigger;
        if (wctl.erase_trigger && wctl.erase_enable && ctrl_q.erase_enable
            && erase_arm_q) begin
          ctrl_d.erase_trigger = 1'b1;
          state_d              = nvm_ctrl_pkg::ST_ERASE;
          cnt_d                = erase_cyc;
        end else if (wctl.write_trigger && wctl.write_enable_bit
                     && ctrl_q.write_enable_bit && write_arm_q) begin
          ctrl_d.write_trigger = 1'b1;
          if (ctrl_q.page_mode) begin
            state_d = nvm_ctrl_pkg::ST_PROGRAM;
            cnt_d   = write_cyc;
          end else begin
            state_d = nvm_ctrl_pkg::ST_BYTE_ERASE;
            cnt_d   = erase_cyc;
          end
        end
      end
    end

    // Cycle timer
    if (!idle && !end_q) begin
      if (cnt_q <= 32'h1) begin
        end_d = 1'b1;
      end else begin
        cnt_d = cnt_q - 32'h1;
      end
    end

    if (byte_erase_go) begin
      state_d = nvm_ctrl_pkg::ST_PROGRAM;
      cnt_d   = write_cyc;
    end
    if (erase_go) begin
      state_d              = nvm_ctrl_pkg::ST_IDLE;
      ctrl_d.erase_trigger = 1'b0;
      clr_ee_d             = 1'b1;
    end
    if (program_go) begin
      state_d              = nvm_ctrl_pkg::ST_IDLE;
      ctrl_d.write_trigger = 1'b0;
      clr_we_d             = 1'b1;
    end
    // Enable drops one cycle after its trigger
    if (clr_ee_q) begin
      ctrl_d.erase_enable = 1'b0;
    end
    if (clr_we_q) begin
      ctrl_d.write_enable_bit = 1'b0;
    end

    // Done flag: software clears by writing zero, a cycle end wins
    if (REG_WR && (REG_ADDR == nvm_ctrl_pkg::REG_DONE) && !REG_WDATA[0]) begin
      done_d = 1'b0;
    end
    if (erase_go || program_go) begin
      done_d = 1'b1;
    end

    // Falling enables empty the buffer; rising ones do not
    if ((prev_ee_q && !ctrl_q.erase_enable) || (prev_we_q && !ctrl_q.write_enable_bit)) begin
      for (int i = 0; i < NB; i++) begin
        buf_d[i] = nvm_ctrl_pkg::BYTE_RST;
      end
      tag_d = '0;
    end

    if (REG_RD) begin
      if (REG_ADDR == nvm_ctrl_pkg::REG_ADDR_LOW) begin
        rdata_d = addr_low_q;
      end else if (REG_ADDR == nvm_ctrl_pkg::REG_ADDR_HIGH) begin
        rdata_d = {5'h00, addr_high_q};
      end else if (REG_ADDR == nvm_ctrl_pkg::REG_DATA) begin
        rdata_d = data_q;
      end else if (REG_ADDR == nvm_ctrl_pkg::REG_CTRL) begin
        rdata_d = ctrl_q;
      end else if (REG_ADDR == nvm_ctrl_pkg::REG_DONE) begin
        rdata_d = {7'h00, done_q};
      end else if (REG_ADDR == nvm_ctrl_pkg::REG_ARRAY) begin
        rdata_d = mem_q[full_addr];
      end else begin
        rdata_d = 8'h00;
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      ctrl_q      <= nvm_ctrl_pkg::ctrl_s'(nvm_ctrl_pkg::CTRL_RST);
      state_q     <= nvm_ctrl_pkg::ST_IDLE;
      addr_low_q  <= 8'h00;
      addr_high_q <= 3'h0;
      data_q      <= nvm_ctrl_pkg::BYTE_RST;
      for (int i = 0; i < NB; i++) begin
        buf_q[i] <= nvm_ctrl_pkg::BYTE_RST;
      end
      tag_q       <= '0;
      sat_q       <= 1'b0;
      erase_arm_q <= 1'b0;
      write_arm_q <= 1'b0;
      prev_ee_q   <= 1'b0;
      prev_we_q   <= 1'b0;
      cnt_q       <= 32'h0;
      end_q       <= 1'b0;
      clr_ee_q    <= 1'b0;
      clr_we_q    <= 1'b0;
      done_q      <= 1'b0;
      rdata_q     <= 8'h00;
    end else begin
      ctrl_q      <= ctrl_d;
      state_q     <= state_d;
      addr_low_q  <= addr_low_d;
      addr_high_q <= addr_high_d;
      data_q      <= data_d;
      buf_q       <= buf_d;
      tag_q       <= tag_d;
      sat_q       <= sat_d;
      erase_arm_q <= erase_arm_d;
      write_arm_q <= write_arm_d;
      prev_ee_q   <= prev_ee_d;
      prev_we_q   <= prev_we_d;
      cnt_q       <= cnt_d;
      end_q       <= end_d;
      clr_ee_q    <= clr_ee_d;
      clr_we_q    <= clr_we_d;
      done_q      <= done_d;
      rdata_q     <= rdata_d;
    end
  end

  // ==========================================================================
  // Array: nonvolatile in intent, so reset leaves its content alone
  always_comb begin
    mem_d = mem_q;
    if (erase_go) begin
      if (ctrl_q.page_mode) begin
        for (int i = 0; i < NB; i++) begin
          if (tag_q[i]) begin
            mem_d[{full_addr[10:4], 4'(i)}] = 8'h00;
          end
        end
      end else begin
        mem_d[full_addr] = 8'h00;
      end
    end
    if (byte_erase_go) begin
      mem_d[full_addr] = 8'h00;
    end
    if (program_go) begin
      if (ctrl_q.page_mode) begin
        for (int i = 0; i < NB; i++) begin
          if (tag_q[i]) begin
            mem_d[{full_addr[10:4], 4'(i)}] = buf_q[i];
          end
        end
      end else begin
        mem_d[full_addr] = data_q;
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    mem_q <= mem_d;
  end

endmodule

// [verilog/nvm_ctrl_pkg.sv]
// Package: constants, types and register map of the data EEPROM erase/write controller
package nvm_ctrl_pkg;

  // ==========================================================================
  // Geometry
  localparam int          ADDR_W     = 11;
  localparam int          PAGE_W     = 7;
  localparam int          OFS_W      = 4;
  localparam int          PAGE_BYTES = 16;
  localparam int          HIGH_W     = 3;
  localparam logic [3:0]  OFS_LAST   = 4'hf;

  // ==========================================================================
  // Register indices on the plain register port
  localparam logic [2:0]  REG_ADDR_LOW  = 3'h0;
  localparam logic [2:0]  REG_ADDR_HIGH = 3'h1;
  localparam logic [2:0]  REG_DATA      = 3'h2;
  localparam logic [2:0]  REG_CTRL      = 3'h3;
  localparam logic [2:0]  REG_DONE      = 3'h4;
  localparam logic [2:0]  REG_ARRAY     = 3'h5;

  // ==========================================================================
  // Reset values
  localparam logic [7:0]  CTRL_RST = 8'h00;
  localparam logic [7:0]  BYTE_RST = 8'h00;

  // ==========================================================================
  // Cycle times, in ns, and clock rate
  localparam int          CLK_MHZ       = 250;
  localparam int          ERASE_T0_NS   = 3200000;
  localparam int          WRITE_T0_NS   = 2200000;
  localparam int          ERASE_T1_NS   = 3700000;
  localparam int          WRITE_T1_NS   = 3000000;
  localparam int          ERASE_T0_CYC  = ERASE_T0_NS * CLK_MHZ / 1000;
  localparam int          WRITE_T0_CYC  = WRITE_T0_NS * CLK_MHZ / 1000;
  localparam int          ERASE_T1_CYC  = ERASE_T1_NS * CLK_MHZ / 1000;
  localparam int          WRITE_T1_CYC  = WRITE_T1_NS * CLK_MHZ / 1000;

  // ==========================================================================
  // Control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic       cycle_time_select;
    logic       erase_enable;
    logic       erase_trigger;
    logic       page_mode;
    logic       write_enable_bit;
    logic       write_trigger;
    logic [1:0] rsvd;
  } ctrl_s;

  typedef enum logic [1:0] {
    ST_IDLE       = 2'b00,
    ST_ERASE      = 2'b01,
    ST_BYTE_ERASE = 2'b10,
    ST_PROGRAM    = 2'b11
  } state_e;

endpackage

// [verilog/nvm_ctrl_top_note.sv]
// Empty on purpose: all controller logic lives in the erase/write controller file

// [tb/nvm_ctrl_properties.sv]
// Concurrent checks on the register port of the erase/write controller
`timescale 1ns/10ps
module nvm_ctrl_properties #(
  parameter int unsigned ERASE_T0_CYC = nvm_ctrl_pkg::ERASE_T0_CYC,
  parameter int unsigned WRITE_T0_CYC = nvm_ctrl_pkg::WRITE_T0_CYC,
  parameter int unsigned ERASE_T1_CYC = nvm_ctrl_pkg::ERASE_T1_CYC,
  parameter int unsigned WRITE_T1_CYC = nvm_ctrl_pkg::WRITE_T1_CYC
) (
  input wire logic       CLK_SYS,
  input wire logic       RST_N,
  input wire logic [2:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic       REG_WR,
  input wire logic       REG_RD,
  input wire logic [7:0] REG_RDATA,
  input wire logic       NVM_DONE_FLAG,
  input wire logic       BUSY
);
  // ==========================================================================
  // Busy length counter
  // Loose bound: all four counts, so it holds whatever select bit is used
  localparam int BUSY_MAX = ERASE_T0_CYC + WRITE_T0_CYC + ERASE_T1_CYC + WRITE_T1_CYC;
  int busy_q;
  int busy_d;
  always_comb busy_d = BUSY ? busy_q + 1 : 0;
  always_ff @(posedge CLK_SYS) busy_q <= !RST_N ? 0 : busy_d;

  // ==========================================================================
  // Sequences
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  sequence wr_arm;
    REG_WR && REG_ADDR == nvm_ctrl_pkg::REG_CTRL && !BUSY && REG_WDATA[3:2] == 2'b10
    ##1 REG_WR && REG_ADDR == nvm_ctrl_pkg::REG_CTRL && REG_WDATA[3:2] == 2'b11;
  endsequence
  sequence erase_arm_seq;
    REG_WR && REG_ADDR == nvm_ctrl_pkg::REG_CTRL && !BUSY && REG_WDATA[6:5] == 2'b10
    ##1 REG_WR && REG_ADDR == nvm_ctrl_pkg::REG_CTRL && REG_WDATA[6:5] == 2'b11;
  endsequence
  sequence cycle_end;
    $fell(BUSY);
  endsequence

  // ==========================================================================
  // Assertions
  a_write_arm_start: assert property (wr_arm |=> BUSY)
    else $error("write arm did not start a cycle");
  a_erase_arm_start: assert property (erase_arm_seq |=> BUSY)
    else $error("erase arm did not start a cycle");
  a_no_enable_start: assert property (!BUSY && REG_WR && REG_ADDR == nvm_ctrl_pkg::REG_CTRL
    && !REG_WDATA[6] && !REG_WDATA[3] |=> !BUSY)
    else $error("cycle started without enable");
  a_start_needs_pair: assert property ($rose(BUSY) |-> $past(REG_WR) && $past(REG_WR, 2)
    && $past(REG_ADDR) == nvm_ctrl_pkg::REG_CTRL && $past(REG_ADDR, 2) == nvm_ctrl_pkg::REG_CTRL)
    else $error("cycle started without two control writes");
  a_busy_bounded: assert property (busy_q <= BUSY_MAX)
    else $error("cycle runs too long");
  a_end_sets_done: assert property (cycle_end |-> NVM_DONE_FLAG)
    else $error("done flag not set at cycle end");
  a_done_needs_end: assert property ($rose(NVM_DONE_FLAG) |-> $fell(BUSY))
    else $error("done flag set without cycle end");
  a_done_sticky: assert property (NVM_DONE_FLAG && !(REG_WR && REG_ADDR == nvm_ctrl_pkg::REG_DONE
    && !REG_WDATA[0]) |=> NVM_DONE_FLAG)
    else $error("done flag dropped on its own");
  a_busy_trig_shown: assert property (REG_RD && REG_ADDR == nvm_ctrl_pkg::REG_CTRL && BUSY
    |=> REG_RDATA[5] || REG_RDATA[2])
    else $error("trigger not visible while busy");
  a_idle_trig_clear: assert property (REG_RD && REG_ADDR == nvm_ctrl_pkg::REG_CTRL && !BUSY
    |=> REG_RDATA[5:4] != 2'b10 && !REG_RDATA[5] && !REG_RDATA[2])
    else $error("trigger set while idle");
  a_rdata_idle_zero: assert property (!$past(REG_RD) |-> REG_RDATA == 8'h00)
    else $error("read data outside read slot");
endmodule

// [tb/nvm_core_model.sv]
// Processor core model: master of the plain register port
`timescale 1ns/10ps
module nvm_core_model (
  input  wire logic       CLK_SYS,
  input  wire logic [7:0] REG_RDATA,
  output logic      [2:0] REG_ADDR,
  output logic      [7:0] REG_WDATA,
  output logic            REG_WR,
  output logic            REG_RD
);
  // Program mask only; no interrupt source exists in this bench
  logic global_irq_enable;
  initial begin
    REG_ADDR          = 3'h0;
    REG_WDATA         = 8'h00;
    REG_WR            = 1'b0;
    REG_RD            = 1'b0;
    global_irq_enable = 1'b1;
  end
  // ==========================================================================
  // Bus cycles; the write strobe is held across back-to-back writes
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge CLK_SYS);
    REG_WR    <= 1'b1;
    REG_RD    <= 1'b0;
    REG_ADDR  <= a;
    REG_WDATA <= d;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge CLK_SYS);
    REG_WR    <= 1'b0;
    REG_RD    <= 1'b1;
    REG_ADDR  <= a;
    REG_WDATA <= ~REG_WDATA;
    @(posedge CLK_SYS);
    REG_RD <= 1'b0;
    #1;
    d = REG_RDATA;
  endtask
  task automatic idle();
    @(posedge CLK_SYS);
    REG_WR    <= 1'b0;
    REG_RD    <= 1'b0;
    REG_WDATA <= ~REG_WDATA;
  endtask
  // Masked so nothing can slip between the enable and the trigger
  task automatic arm(input logic [7:0] en, input logic [7:0] trig);
    global_irq_enable = 1'b0;
    wr(nvm_ctrl_pkg::REG_CTRL, en);
    wr(nvm_ctrl_pkg::REG_CTRL, trig);
    global_irq_enable = 1'b1;
  endtask
endmodule

// [tb/data_eeprom_erase_write_ctrl_tb.sv]
// Self-checking bench of the erase/write controller
`timescale 1ns/10ps
module data_eeprom_erase_write_ctrl_tb;
  localparam logic [2:0] A_LOW  = nvm_ctrl_pkg::REG_ADDR_LOW;
  localparam logic [2:0] A_HIGH = nvm_ctrl_pkg::REG_ADDR_HIGH;
  localparam logic [2:0] A_DATA = nvm_ctrl_pkg::REG_DATA;
  localparam logic [2:0] A_CTRL = nvm_ctrl_pkg::REG_CTRL;
  localparam logic [2:0] A_DONE = nvm_ctrl_pkg::REG_DONE;
  localparam logic [2:0] A_ARR  = nvm_ctrl_pkg::REG_ARRAY;
  logic       CLK_SYS = 1'b0;
  logic       RST_N   = 1'b0;
  logic [2:0] REG_ADDR;
  logic [7:0] REG_WDATA;
  logic       REG_WR;
  logic       REG_RD;
  logic [7:0] REG_RDATA;
  logic       NVM_DONE_FLAG;
  logic       BUSY;
  int         err_count   = 0;
  int         checks_done = 0;
  int         cyc         = 0;
  int         busy_len;
  int         t0;
  always #2 CLK_SYS = ~CLK_SYS;
  // Short counts keep the run small: 20/12 and 25/16 cycles
  nvm_erase_write_ctrl #(.ERASE_T0_CYC(20), .WRITE_T0_CYC(12), .ERASE_T1_CYC(25),
    .WRITE_T1_CYC(16)) DUT (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .NVM_DONE_FLAG(NVM_DONE_FLAG), .BUSY(BUSY));
  nvm_core_model core (.CLK_SYS(CLK_SYS), .REG_RDATA(REG_RDATA), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD));
  // ==========================================================================
  // Helpers
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  always @(posedge CLK_SYS) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      err_count++;
      test_done();
    end
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rdchk(input logic [2:0] a, input logic [7:0] e, input string n);
    logic [7:0] d;
    core.rd(a, d);
    chk(n, e, d);
  endtask
  task automatic arr(input logic [7:0] lo, input logic [7:0] e);
    core.wr(A_HIGH, 8'h01);
    core.wr(A_LOW, lo);
    rdchk(A_ARR, e, "array byte");
  endtask
  // Zero expectation skips the in-cycle control check
  task automatic wait_done(input logic [7:0] e);
    logic [7:0] d;
    int n;
    core.rd(A_CTRL, d);
    if (e != 8'h00) chk("ctrl while busy", e, d);
    n = 0;
    while (BUSY !== 1'b0 && n < 200) begin
      @(posedge CLK_SYS);
      #1;
      n++;
    end
    busy_len = n;
    if (n >= 200) chk("cycle end", 8'h00, 8'h01);
    repeat (3) @(posedge CLK_SYS);
  endtask
  task automatic bytewr(input logic [7:0] lo, input logic [7:0] d, input logic sel);
    core.wr(A_LOW, lo);
    core.wr(A_DATA, d);
    core.arm({sel, 7'h08}, {sel, 7'h0c});
    wait_done({sel, 7'h0c});
    rdchk(A_CTRL, {sel, 7'h00}, "ctrl after write");
    rdchk(A_DONE, 8'h01, "done set");
    core.wr(A_DONE, 8'h00);
    rdchk(A_DONE, 8'h00, "done cleared");
    arr(lo, d);
  endtask
  task automatic do_reset();
    RST_N <= 1'b0;
    repeat (16) @(posedge CLK_SYS);
    RST_N <= 1'b1;
  endtask
  // ==========================================================================
  // Main sequence
  initial begin
    do_reset();
    rdchk(A_CTRL, 8'h00, "ctrl reset");
    rdchk(A_DONE, 8'h00, "done reset");
    rdchk(3'h6, 8'h00, "unmapped");
    core.wr(A_HIGH, 8'h01);
    bytewr(8'h4e, 8'ha5, 1'b0);
    t0 = busy_len;
    bytewr(8'h4e, 8'h5a, 1'b1);
    chk("time select", 8'h09, 8'(busy_len - t0));
    bytewr(8'h4d, 8'h3c, 1'b0);
    core.wr(A_CTRL, 8'h04);
    core.wr(A_CTRL, 8'h20);
    rdchk(A_CTRL, 8'h00, "lone trigger");
    core.wr(A_CTRL, 8'h08);
    rdchk(A_DATA, 8'h3c, "data reg");
    core.wr(A_CTRL, 8'h0c);
    rdchk(A_CTRL, 8'h08, "split arm");
    // Page erase of two tagged bytes; third dummy write lands on the stop
    core.wr(A_CTRL, 8'h10);
    core.wr(A_LOW, 8'h4e);
    repeat (3) core.wr(A_DATA, 8'hff);
    rdchk(A_LOW, 8'h4f, "low saturates");
    rdchk(A_HIGH, 8'h01, "page kept");
    core.arm(8'h50, 8'h70);
    wait_done(8'h70);
    rdchk(A_CTRL, 8'h10, "ctrl after erase");
    arr(8'h4e, 8'h00);
    arr(8'h4f, 8'h00);
    arr(8'h4d, 8'h3c);
    // Page write over the erased bytes, third byte past the stop
    core.wr(A_LOW, 8'h4e);
    core.wr(A_DATA, 8'h11);
    core.wr(A_DATA, 8'h22);
    core.wr(A_DATA, 8'h33);
    core.arm(8'h18, 8'h1c);
    wait_done(8'h1c);
    rdchk(A_CTRL, 8'h10, "ctrl after page write");
    arr(8'h4e, 8'h11);
    arr(8'h4f, 8'h22);
    // Enable falling empties the buffer
    core.wr(A_LOW, 8'h4d);
    core.wr(A_DATA, 8'h99);
    core.wr(A_CTRL, 8'h18);
    core.wr(A_CTRL, 8'h10);
    core.arm(8'h18, 8'h1c);
    wait_done(8'h00);
    arr(8'h4d, 8'h3c);
    core.wr(A_LOW, 8'h4d);
    core.wr(A_DATA, 8'h00);
    core.wr(A_CTRL, 8'h50);
    core.wr(A_CTRL, 8'h10);
    core.arm(8'h50, 8'h70);
    wait_done(8'h00);
    arr(8'h4d, 8'h3c);
    // Reset in mid-run empties the buffer
    core.wr(A_LOW, 8'h4d);
    core.wr(A_DATA, 8'h99);
    core.idle();
    do_reset();
    core.wr(A_CTRL, 8'h10);
    core.arm(8'h18, 8'h1c);
    wait_done(8'h00);
    arr(8'h4d, 8'h3c);
    test_done();
  end
endmodule

bind nvm_erase_write_ctrl nvm_ctrl_properties #(
  .ERASE_T0_CYC(ERASE_T0_CYC),
  .WRITE_T0_CYC(WRITE_T0_CYC),
  .ERASE_T1_CYC(ERASE_T1_CYC),
  .WRITE_T1_CYC(WRITE_T1_CYC)
) u_props (
  .CLK_SYS(CLK_SYS),
  .RST_N(RST_N),
  .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA),
  .REG_WR(REG_WR),
  .REG_RD(REG_RD),
  .REG_RDATA(REG_RDATA),
  .NVM_DONE_FLAG(NVM_DONE_FLAG),
  .BUSY(BUSY)
);
